// *** acsr_regs.sv ***
// Autonegotiation control, status and low advertisement registers.
// Assumes the negotiation engine and link monitor run on the same
// clock and report single-cycle event pulses and status levels.
`timescale 1ns/100ps
`default_nettype none
module acsr_regs
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Management access
  input wire acsr_pkg::acsr_mgmt_req_t mgmt_req,
  output logic mgmt_ack,
  output logic [15:0] mgmt_rdata,
  // Negotiation engine
  input wire acsr_pkg::acsr_eng_status_t eng_status,
  input wire logic role_master_in,
  output logic autoneg_enable,
  output logic autoneg_restart,
  output acsr_pkg::acsr_adv_t tx_adv
);
  import acsr_pkg::*;

  acsr_restart_state_t rs_q;
  acsr_restart_state_t rs_d;
  logic enable_q;
  logic page_flag_q;
  logic page_hold_q;
  logic first_seen_q;
  logic fault_flag_q;
  logic link_ll_q;
  logic ack_q;
  logic next_page_q;
  logic local_fault_q;
  logic force_q;
  logic [1:0] pause_q;
  logic ack_out_q;
  logic [15:0] rdata_q;
  acsr_adv_t adv_q;

  // Address decode
  wire dev_hit = mgmt_req.valid && (mgmt_req.dev == ACSR_MMD_DEV);
  wire ctrl_sel = dev_hit && (mgmt_req.addr == ACSR_CTRL_ADDR);
  wire stat_sel = dev_hit && (mgmt_req.addr == ACSR_STAT_ADDR);
  wire advl_sel = dev_hit && (mgmt_req.addr == ACSR_ADVL_ADDR);
  wire ctrl_wr = ctrl_sel && mgmt_req.write;
  wire advl_wr = advl_sel && mgmt_req.write;
  wire stat_rd = stat_sel && !mgmt_req.write;
  wire restart_wr = ctrl_wr && mgmt_req.wdata[ACSR_CTRL_RESTART_BIT];

  // Restart handshake: held until the engine reports the new start
  always_comb
  begin
    rs_d = rs_q;
    case (rs_q)
      ACSR_RS_IDLE:
      begin
        if (restart_wr)
          rs_d = ACSR_RS_PEND;
      end
      ACSR_RS_PEND:
      begin
        if (eng_status.restart_started && !restart_wr)
          rs_d = ACSR_RS_IDLE;
      end
      default:
        rs_d = ACSR_RS_IDLE;
    endcase
  end

  // First page of a negotiation is reported only once partner page is valid
  wire page_event = eng_status.page_stored || page_hold_q;
  wire page_ok = first_seen_q || eng_status.lp_valid;
  wire page_set = page_event && page_ok;
  wire page_hold_d = page_event && !page_ok;
  wire first_seen_d = eng_status.restart_started ? 1'b0 : (first_seen_q || page_set);
  wire fault_set = eng_status.page_stored && eng_status.base_page
    && eng_status.partner_fault;

  // Complete only while enabled and everything is valid
  wire done_now = enable_q && eng_status.complete && eng_status.link_up
    && eng_status.adv_valid && eng_status.lp_valid;

  wire [15:0] ctrl_word = {3'h0, enable_q, 2'h0, (rs_q == ACSR_RS_PEND), 9'h000};
  wire [15:0] stat_word = {9'h000, page_flag_q, done_now, fault_flag_q, 1'b1,
    link_ll_q, 2'h0};
  wire [15:0] advl_word = {next_page_q, ack_q, local_fault_q, force_q, pause_q,
    5'h00, ACSR_SELECTOR_8023};
  wire [15:0] rdata_d = ctrl_sel ? ctrl_word :
                        stat_sel ? stat_word :
                        advl_sel ? advl_word : 16'h0000;

  wire acsr_adv_t adv_d = '{
    next_page_request: next_page_q,
    codeword_acknowledge: ack_q,
    local_fault_advertise: local_fault_q,
    force_role: force_q,
    advertised_role_master: role_master_in,
    pause_ability: pause_q,
    selector_field: ACSR_SELECTOR_8023
  };

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rs_q <= ACSR_RS_IDLE;
    else
      rs_q <= rs_d;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      enable_q <= ACSR_CTRL_RESET[ACSR_CTRL_ENABLE_BIT];
    else if (ctrl_wr)
      enable_q <= mgmt_req.wdata[ACSR_CTRL_ENABLE_BIT];
  end

  // Latched status: a new event in the read cycle wins over the clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      page_flag_q <= ACSR_STAT_RESET[ACSR_STAT_PAGE_BIT];
      fault_flag_q <= ACSR_STAT_RESET[ACSR_STAT_FAULT_BIT];
      page_hold_q <= 1'b0;
      first_seen_q <= 1'b0;
    end
    else
    begin
      page_flag_q <= (page_flag_q && !stat_rd) || page_set;
      fault_flag_q <= (fault_flag_q && !stat_rd) || fault_set;
      page_hold_q <= page_hold_d;
      first_seen_q <= first_seen_d;
    end
  end

  // Link latch low: a read reloads the present link level
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      link_ll_q <= ACSR_STAT_RESET[ACSR_STAT_LINK_BIT];
    else if (stat_rd)
      link_ll_q <= eng_status.link_up;
    else if (!eng_status.link_up)
      link_ll_q <= 1'b0;
  end

  // Acknowledge set on a received codeword, cleared when a new run starts
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ack_q <= ACSR_ADVL_RESET[ACSR_ADV_ACK_BIT];
    else if (eng_status.page_stored)
      ack_q <= 1'b1;
    else if (eng_status.restart_started)
      ack_q <= 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      next_page_q <= ACSR_ADVL_RESET[ACSR_ADV_NP_BIT];
      local_fault_q <= ACSR_ADVL_RESET[ACSR_ADV_FAULT_BIT];
      force_q <= ACSR_ADVL_RESET[ACSR_ADV_FORCE_BIT];
      pause_q <= ACSR_ADVL_RESET[ACSR_ADV_PAUSE_HI:ACSR_ADV_PAUSE_LO];
    end
    else if (advl_wr)
    begin
      next_page_q <= mgmt_req.wdata[ACSR_ADV_NP_BIT];
      local_fault_q <= mgmt_req.wdata[ACSR_ADV_FAULT_BIT];
      force_q <= mgmt_req.wdata[ACSR_ADV_FORCE_BIT];
      pause_q <= mgmt_req.wdata[ACSR_ADV_PAUSE_HI:ACSR_ADV_PAUSE_LO];
    end
  end

  // Read data and acknowledge one cycle after each request
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_out_q <= 1'b0;
      rdata_q <= 16'h0000;
      adv_q <= '0;
    end
    else
    begin
      ack_out_q <= mgmt_req.valid;
      rdata_q <= rdata_d;
      adv_q <= adv_d;
    end
  end

  assign mgmt_ack = ack_out_q;
  assign mgmt_rdata = rdata_q;
  assign autoneg_enable = enable_q;
  assign autoneg_restart = (rs_q == ACSR_RS_PEND);
  assign tx_adv = adv_q;

endmodule
`default_nettype wire

// *** acsr_pkg.sv ***
// Constants, field layouts and carrier types of the autonegotiation
// control, status and low advertisement register bank.
// Assumes one device clock and a management port that carries a
// device address, a register address and 16-bit data.
package acsr_pkg;

  localparam logic [4:0] ACSR_MMD_DEV = 5'h07;
  localparam logic [15:0] ACSR_CTRL_ADDR = 16'h0200;
  localparam logic [15:0] ACSR_STAT_ADDR = 16'h0201;
  localparam logic [15:0] ACSR_ADVL_ADDR = 16'h0202;

  localparam logic [15:0] ACSR_CTRL_RESET = 16'h1000;
  localparam logic [15:0] ACSR_STAT_RESET = 16'h0008;
  localparam logic [15:0] ACSR_ADVL_RESET = 16'h0001;

  localparam int ACSR_CTRL_ENABLE_BIT = 12;
  localparam int ACSR_CTRL_RESTART_BIT = 9;

  localparam int ACSR_STAT_PAGE_BIT = 6;
  localparam int ACSR_STAT_DONE_BIT = 5;
  localparam int ACSR_STAT_FAULT_BIT = 4;
  localparam int ACSR_STAT_ABLE_BIT = 3;
  localparam int ACSR_STAT_LINK_BIT = 2;

  localparam int ACSR_ADV_NP_BIT = 15;
  localparam int ACSR_ADV_ACK_BIT = 14;
  localparam int ACSR_ADV_FAULT_BIT = 13;
  localparam int ACSR_ADV_FORCE_BIT = 12;
  localparam int ACSR_ADV_PAUSE_HI = 11;
  localparam int ACSR_ADV_PAUSE_LO = 10;
  localparam int ACSR_ADV_SEL_HI = 4;
  localparam int ACSR_ADV_SEL_LO = 0;

  localparam logic [4:0] ACSR_SELECTOR_8023 = 5'h01;
  localparam logic ACSR_ROLE_SLAVE = 1'b0;
  localparam logic ACSR_ROLE_MASTER = 1'b1;

  typedef enum logic [1:0] {
    ACSR_RS_IDLE = 2'b01,
    ACSR_RS_PEND = 2'b10
  } acsr_restart_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] dev;
    logic [15:0] addr;
    logic [15:0] wdata;
  } acsr_mgmt_req_t;

  typedef struct packed {
    logic restart_started;
    logic page_stored;
    logic base_page;
    logic partner_fault;
    logic complete;
    logic link_up;
    logic adv_valid;
    logic lp_valid;
  } acsr_eng_status_t;

  typedef struct packed {
    logic next_page_request;
    logic codeword_acknowledge;
    logic local_fault_advertise;
    logic force_role;
    logic advertised_role_master;
    logic [1:0] pause_ability;
    logic [4:0] selector_field;
  } acsr_adv_t;

endpackage

// *** acsr_props.sv ***
// Port checker of the negotiation register bank.
// Bound to acsr_regs; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module acsr_props
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Management access
  input wire acsr_pkg::acsr_mgmt_req_t mgmt_req,
  input wire logic mgmt_ack,
  input wire logic [15:0] mgmt_rdata,
  // Negotiation engine
  input wire acsr_pkg::acsr_eng_status_t eng_status,
  input wire logic role_master_in,
  input wire logic autoneg_enable,
  input wire logic autoneg_restart,
  input wire acsr_pkg::acsr_adv_t tx_adv
);
  import acsr_pkg::*;
  wire logic hit = mgmt_req.valid && mgmt_req.dev == ACSR_MMD_DEV;
  wire logic wr_c = hit && mgmt_req.write && mgmt_req.addr == ACSR_CTRL_ADDR;
  wire logic rd_s = hit && !mgmt_req.write && mgmt_req.addr == ACSR_STAT_ADDR;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_ACK: assert property (mgmt_req.valid |=> mgmt_ack) else $error("no ack");
  AST_RS_SET: assert property (wr_c && mgmt_req.wdata[9] |=> autoneg_restart)
    else $error("restart not set");
  AST_RS_HOLD: assert property (autoneg_restart && !eng_status.restart_started
    |=> autoneg_restart) else $error("restart dropped");
  AST_RS_CLR: assert property (autoneg_restart && eng_status.restart_started && !wr_c
    |=> !autoneg_restart) else $error("restart stuck");
  AST_EN: assert property (wr_c |=> autoneg_enable == $past(mgmt_req.wdata[12]))
    else $error("enable");
  AST_ABLE: assert property (rd_s |=> mgmt_rdata[3]) else $error("able");
  AST_DONE: assert property (rd_s && !autoneg_enable |=> !mgmt_rdata[5])
    else $error("done");
  AST_LINK: assert property (rd_s && !$past(eng_status.link_up) |=> !mgmt_rdata[2])
    else $error("link");
  AST_SEL: assert property (mgmt_ack |-> tx_adv.selector_field == ACSR_SELECTOR_8023)
    else $error("selector");
  AST_ACKB: assert property (eng_status.page_stored |-> ##2 tx_adv.codeword_acknowledge)
    else $error("ack bit");
endmodule
bind acsr_regs acsr_props i_acsr_props (.clock(clock), .rst_n(rst_n), .mgmt_req(mgmt_req),
  .mgmt_ack(mgmt_ack), .mgmt_rdata(mgmt_rdata), .eng_status(eng_status),
  .role_master_in(role_master_in), .autoneg_enable(autoneg_enable),
  .autoneg_restart(autoneg_restart), .tx_adv(tx_adv));
`default_nettype wire

// *** acsr_engine_model.sv ***
// Behavioural negotiation engine facing the register bank.
// Same clock; the bench sets page, fault and link levels.
`timescale 1ns/100ps
`default_nettype none
module acsr_engine_model
#(
  parameter logic [3:0] DELAY = 4'hC
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Controls
  input wire logic autoneg_restart,
  input wire logic page_go,
  input wire logic fault,
  input wire logic up,
  // Engine status
  output var acsr_pkg::acsr_eng_status_t eng_status
);
  import acsr_pkg::*;
  logic [3:0] cnt_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 4'h0;
    else
      cnt_q <= autoneg_restart ? cnt_q + 4'h1 : 4'h0;
  end
  // Slow start: the restart stays pending for DELAY plus one cycles
  assign eng_status = '{restart_started: autoneg_restart && cnt_q == DELAY,
    page_stored: page_go, base_page: 1'b1, partner_fault: fault,
    complete: up, link_up: up, adv_valid: 1'b1, lp_valid: up};
endmodule
`default_nettype wire

// *** acsr_regs_tb.sv ***
// Testbench of the negotiation register bank.
// Inputs change on the falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module acsr_regs_tb;
  import acsr_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  acsr_mgmt_req_t req = '0;
  logic up = 1'b0, pg = 1'b0, flt = 1'b0, role = 1'b1, ack, en, rs;
  logic [15:0] rd;
  acsr_eng_status_t st;
  acsr_adv_t adv;
  int mismatches = 0;
  int checks = 0;
  acsr_regs i_acsr_regs (.clock(clock), .rst_n(rst_n), .mgmt_req(req), .mgmt_ack(ack),
    .mgmt_rdata(rd), .eng_status(st), .role_master_in(role), .autoneg_enable(en),
    .autoneg_restart(rs), .tx_adv(adv));
  acsr_engine_model i_acsr_engine_model (.clock(clock), .rst_n(rst_n),
    .autoneg_restart(rs), .page_go(pg), .fault(flt), .up(up), .eng_status(st));
  initial
  begin
    forever #2 clock = ~clock;
  end
  task close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // One idle edge before each access keeps valid from being lowered and raised at once
  task acc(input logic w, input logic [4:0] d, input logic [15:0] a, input logic [15:0] v);
    @(negedge clock);
    req = '{1'b1, w, d, a, v};
    @(negedge clock);
    req.valid = 1'b0;
    cmp("ack", 16'h0001, {15'h0, ack});
  endtask
  task rdr(input logic [15:0] a, input logic [15:0] e);
    acc(1'b0, ACSR_MMD_DEV, a, 16'h0);
    cmp($sformatf("reg %h", a), e, rd);
  endtask
  initial
  begin
    #40000;
    mismatches++;
    close_out;
  end
  initial
  begin
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    rdr(ACSR_CTRL_ADDR, 16'h1000);
    rdr(ACSR_STAT_ADDR, 16'h0008);
    rdr(ACSR_ADVL_ADDR, 16'h0001);
    acc(1'b1, 5'h03, ACSR_CTRL_ADDR, 16'h0000);
    rdr(ACSR_CTRL_ADDR, 16'h1000);
    rdr(16'h0203, 16'h0000);
    acc(1'b1, ACSR_MMD_DEV, ACSR_ADVL_ADDR, 16'hFFFF);
    rdr(ACSR_ADVL_ADDR, 16'hBC01);
    cmp("tx", 16'h0BE1, {4'h0, adv});
    role = 1'b0;
    repeat (2) @(negedge clock);
    cmp("tx", 16'h0B61, {4'h0, adv});
    acc(1'b1, ACSR_MMD_DEV, ACSR_CTRL_ADDR, 16'h1200);
    rdr(ACSR_CTRL_ADDR, 16'h1200);
    acc(1'b1, ACSR_MMD_DEV, ACSR_CTRL_ADDR, 16'h1000);
    rdr(ACSR_CTRL_ADDR, 16'h1200);
    for (int i = 0; i < 30 && rs; i++) @(negedge clock);
    rdr(ACSR_CTRL_ADDR, 16'h1000);
    up = 1'b1;
    flt = 1'b1;
    pg = 1'b1;
    @(negedge clock);
    pg = 1'b0;
    @(negedge clock);
    rdr(ACSR_STAT_ADDR, 16'h0078);
    rdr(ACSR_STAT_ADDR, 16'h002C);
    rdr(ACSR_ADVL_ADDR, 16'hFC01);
    up = 1'b0;
    @(negedge clock);
    up = 1'b1;
    rdr(ACSR_STAT_ADDR, 16'h0028);
    rdr(ACSR_STAT_ADDR, 16'h002C);
    acc(1'b1, ACSR_MMD_DEV, ACSR_CTRL_ADDR, 16'h0000);
    cmp("en", 16'h0000, {15'h0, en});
    rdr(ACSR_STAT_ADDR, 16'h000C);
    acc(1'b1, ACSR_MMD_DEV, ACSR_CTRL_ADDR, 16'h1000);
    cmp("en", 16'h0001, {15'h0, en});
    // First page of a new run arrives before the partner page is valid
    acc(1'b1, ACSR_MMD_DEV, ACSR_CTRL_ADDR, 16'h1200);
    for (int j = 0; j < 30 && rs; j++) @(negedge clock);
    up = 1'b0;
    pg = 1'b1;
    @(negedge clock);
    pg = 1'b0;
    rdr(ACSR_STAT_ADDR, 16'h0018);
    up = 1'b1;
    rdr(ACSR_STAT_ADDR, 16'h0068);
    close_out;
  end
endmodule
`default_nettype wire
